// ==== logic/an_ability_regs.sv ====
// autonegotiation local advertisement and partner ability register bank
//
// Behaviour
// RULE1 - middle advert word at 0x0203, resets 0x4000
// RULE2 - bit 14 long reach, writable, resets one
// RULE3 - bit 4 role, writable, strap reset
// RULE4 - role forcing bit makes role forced
// RULE5 - role sent as nonce bit four
// RULE6 - high word bit 13 high-swing capable
// RULE7 - high word bit 12 high-swing request
// RULE8 - either not capable gives low level
// RULE9 - both capable, any request gives high
// RULE10 - low-word read snapshots middle, high words
// RULE11 - partner low bit 15 next page
// RULE12 - partner low bit 14 acknowledge
// RULE13 - partner low bit 13 remote fault
// RULE14 - partner low bits 11:10 pause ability
// RULE15 - partner low bits 4:0 selector
// RULE16 - forcing bit zero prefers, one forces
// RULE17 - middle, high reads return snapshot
// RULE18 - straps sampled at reset, kept until written
// RULE19 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module an_ability_regs
  import an_regs_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic [4:0] I_MMD,
  input wire logic [15:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  input wire logic I_STRAP_ROLE,
  input wire logic I_STRAP_HS_CAPABLE,
  input wire logic I_STRAP_HS_REQUEST,
  input wire logic I_ROLE_FORCED,
  input wire logic I_RX_VALID,
  input wire logic [15:0] I_RX_LOW,
  input wire logic [15:0] I_RX_MID,
  input wire logic [15:0] I_RX_HIGH,
  output logic O_TX_NONCE_ROLE,
  output logic O_ROLE_FORCED,
  output logic O_LONG_REACH,
  output logic O_HS_CAPABLE,
  output logic O_HS_REQUEST,
  output logic O_HIGH_LEVEL
);
  // strap pins come from the board: two flops before use
  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic strap_taken;
    logic [1:0] strap_age;
    logic [15:0] local_mid;
    logic [15:0] local_high;
    logic [15:0] partner_low;
    logic [15:0] partner_mid;
    logic [15:0] partner_high;
    logic [15:0] rdata;
    logic tx_role;
    logic role_forced;
    logic long_reach;
    logic hs_capable;
    logic hs_request;
    logic high_level;
  } bank_state_t;
  bank_state_t st_ff, nxt_st;

  snap_if sn();

  function automatic logic hit(input logic [15:0] addr);
    hit = (I_MMD == MMD_AUTONEG) && (I_ADDR == addr);
  endfunction

  // transmit level resolution shared by both ends of the link
  function automatic logic resolve_high(input logic [15:0] loc,
                                        input logic [15:0] par);
    logic both_cap;
    logic any_req;
    both_cap = loc[BIT_HS_CAPABLE] && par[BIT_HS_CAPABLE];
    any_req = loc[BIT_HS_REQUEST] || par[BIT_HS_REQUEST];
    resolve_high = both_cap && any_req;
  endfunction

  assign sn.capture = I_RD && hit(ADDR_PARTNER_LOW);
  assign sn.live_mid = st_ff.partner_mid;
  assign sn.live_high = st_ff.partner_high;

  partner_snapshot u_snap (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .sn(sn)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.strap_s1 = {I_STRAP_ROLE, I_STRAP_HS_CAPABLE, I_STRAP_HS_REQUEST};
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.rdata = 16'h0000;
    // RULE18 load straps once both sync stages hold them
    // loading earlier would take the reset zeros of the second stage
    if (!st_ff.strap_taken) begin
      if (st_ff.strap_age == STRAP_SETTLE) begin
        nxt_st.strap_taken = 1'b1;
        nxt_st.local_mid[BIT_ROLE] = st_ff.strap_s2[2];
        nxt_st.local_high[BIT_HS_CAPABLE] = st_ff.strap_s2[1];
        nxt_st.local_high[BIT_HS_REQUEST] = st_ff.strap_s2[0];
      end else begin
        nxt_st.strap_age = st_ff.strap_age + 2'h1;
      end
    end
    if (I_RX_VALID) begin
      // RULE11 RULE12 RULE13 RULE14 RULE15 partner fields
      nxt_st.partner_low = I_RX_LOW & MASK_PARTNER_LOW;
      nxt_st.partner_mid = I_RX_MID;
      nxt_st.partner_high = I_RX_HIGH;
    end
    if (I_WR) begin
      // RULE2 RULE3 RULE19 writable bits only
      if (hit(ADDR_LOCAL_MID)) begin
        nxt_st.local_mid = I_WDATA & MASK_LOCAL_MID;
      end
      // RULE6 RULE7 high-swing bits
      if (hit(ADDR_LOCAL_HIGH)) begin
        nxt_st.local_high = I_WDATA & MASK_LOCAL_HIGH;
      end
    end
    if (I_RD) begin
      // RULE17 partner middle and high words read from snapshot
      if (hit(ADDR_LOCAL_MID)) begin
        nxt_st.rdata = st_ff.local_mid;
      end else if (hit(ADDR_LOCAL_HIGH)) begin
        nxt_st.rdata = st_ff.local_high;
      end else if (hit(ADDR_PARTNER_LOW)) begin
        nxt_st.rdata = st_ff.partner_low;
      end else if (hit(ADDR_PARTNER_MID)) begin
        nxt_st.rdata = sn.held_mid;
      end else if (hit(ADDR_PARTNER_HIGH)) begin
        nxt_st.rdata = sn.held_high;
      end
    end
    // RULE5 role onto nonce bit
    nxt_st.tx_role = st_ff.local_mid[BIT_ROLE];
    // RULE4 RULE16 forcing bit qualifies role
    nxt_st.role_forced = I_ROLE_FORCED;
    nxt_st.long_reach = st_ff.local_mid[BIT_LONG_REACH];
    nxt_st.hs_capable = st_ff.local_high[BIT_HS_CAPABLE];
    nxt_st.hs_request = st_ff.local_high[BIT_HS_REQUEST];
    // RULE8 RULE9 level resolution
    nxt_st.high_level = resolve_high(st_ff.local_high, st_ff.partner_high);
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_ff <= '0;
      // RULE1 reset value of middle word
      st_ff.local_mid <= RST_LOCAL_MID;
      st_ff.local_high <= RST_LOCAL_HIGH;
      st_ff.partner_low <= RST_PARTNER_LOW;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_RDATA = st_ff.rdata;
  assign O_TX_NONCE_ROLE = st_ff.tx_role;
  assign O_ROLE_FORCED = st_ff.role_forced;
  assign O_LONG_REACH = st_ff.long_reach;
  assign O_HS_CAPABLE = st_ff.hs_capable;
  assign O_HS_REQUEST = st_ff.hs_request;
  assign O_HIGH_LEVEL = st_ff.high_level;

  sequence s_write_mid;
    I_WR && hit(ADDR_LOCAL_MID);
  endsequence
  sequence s_read_mid;
    I_RD && hit(ADDR_LOCAL_MID);
  endsequence

  a_mid_write_read: assert property (@(posedge I_MCLK)
    disable iff (!I_RESETN) s_write_mid ##1 s_read_mid
    |=> O_RDATA == ($past(I_WDATA, 2) & MASK_LOCAL_MID)) // RULE2
    else $error("middle word readback wrong");
  a_reserved_zero: assert property (@(posedge I_MCLK)
    disable iff (!I_RESETN)
    (st_ff.local_mid & ~MASK_LOCAL_MID) == 16'h0000 &&
    (st_ff.local_high & ~MASK_LOCAL_HIGH) == 16'h0000) // RULE19
    else $error("reserved advertisement bit set");
  a_low_level: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    !(st_ff.local_high[BIT_HS_CAPABLE] && st_ff.partner_high[BIT_HS_CAPABLE])
    |=> !O_HIGH_LEVEL) // RULE8
    else $error("high level without both capable");
  a_high_level: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (st_ff.local_high[BIT_HS_CAPABLE] && st_ff.partner_high[BIT_HS_CAPABLE]
     && (st_ff.local_high[BIT_HS_REQUEST] ||
         st_ff.partner_high[BIT_HS_REQUEST])) |=> O_HIGH_LEVEL) // RULE9
    else $error("high level not resolved");
  a_nonce_role: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    $past(I_RESETN) |->
    O_TX_NONCE_ROLE == $past(st_ff.local_mid[BIT_ROLE])) // RULE5
    else $error("nonce role does not follow advert");
  a_snap_read: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    I_RD && hit(ADDR_PARTNER_MID) |=> O_RDATA == $past(sn.held_mid)) // RULE17
    else $error("partner middle read not from snapshot");
  a_strap_load: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    !st_ff.strap_taken && st_ff.strap_age == STRAP_SETTLE |=>
      st_ff.local_mid[BIT_ROLE] ==
      $past(st_ff.strap_s2[2])) // RULE18
    else $error("role strap not loaded");
  a_partner_mask: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (st_ff.partner_low & ~MASK_PARTNER_LOW) == 16'h0000) // RULE19
    else $error("reserved partner bit set");
  a_partner_fields: assert property (@(posedge I_MCLK)
    disable iff (!I_RESETN) I_RX_VALID |=>
    st_ff.partner_low[15:13] == $past(I_RX_LOW[15:13])) // RULE11
    else $error("partner flags not captured");
  a_forced_out: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    $past(I_RESETN) |-> O_ROLE_FORCED == $past(I_ROLE_FORCED)) // RULE16
    else $error("forcing bit not passed");
  // readback and access decode
  sequence s_write_high;
    I_WR && hit(ADDR_LOCAL_HIGH);
  endsequence
  sequence s_read_high;
    I_RD && hit(ADDR_LOCAL_HIGH);
  endsequence
  sequence s_read_plow;
    I_RD && hit(ADDR_PARTNER_LOW);
  endsequence
  a_high_write_read: assert property (@(posedge I_MCLK) // RULE6
    disable iff (!I_RESETN) s_write_high ##1 s_read_high
    |=> O_RDATA == ($past(I_WDATA, 2) & MASK_LOCAL_HIGH))
    else $error("high word readback wrong");
  a_low_read_data: assert property (@(posedge I_MCLK) // RULE11
    disable iff (!I_RESETN)
    s_read_plow |=> O_RDATA == $past(st_ff.partner_low))
    else $error("partner low word readback wrong");
  a_idle_rdata: assert property (@(posedge I_MCLK) // RULE19
    disable iff (!I_RESETN) !I_RD |=> O_RDATA == 16'h0000)
    else $error("read data left standing");
  a_other_dev_read: assert property (@(posedge I_MCLK) // RULE1
    disable iff (!I_RESETN)
    I_RD && I_MMD != MMD_AUTONEG |=> O_RDATA == 16'h0000)
    else $error("other device read returned data");
  a_other_dev_write: assert property (@(posedge I_MCLK) // RULE1
    disable iff (!I_RESETN)
    st_ff.strap_taken && I_WR && I_MMD != MMD_AUTONEG
    |=> $stable(st_ff.local_mid) && $stable(st_ff.local_high))
    else $error("other device write landed");
  a_unmapped_read: assert property (@(posedge I_MCLK) // RULE19
    disable iff (!I_RESETN) I_RD && I_MMD == MMD_AUTONEG &&
    (I_ADDR < ADDR_LOCAL_MID || I_ADDR > ADDR_PARTNER_HIGH)
    |=> O_RDATA == 16'h0000)
    else $error("unmapped read returned data");
  // local advertisement bits
  a_role_write: assert property (@(posedge I_MCLK) // RULE3
    disable iff (!I_RESETN) s_write_mid
    |=> st_ff.local_mid[BIT_ROLE] == $past(I_WDATA[BIT_ROLE]))
    else $error("role bit write lost");
  a_reach_write: assert property (@(posedge I_MCLK) // RULE2
    disable iff (!I_RESETN) s_write_mid |=>
    st_ff.local_mid[BIT_LONG_REACH] == $past(I_WDATA[BIT_LONG_REACH]))
    else $error("long reach bit write lost");
  a_reach_reset: assert property (@(posedge I_MCLK) // RULE2
    disable iff (!I_RESETN) !st_ff.strap_taken &&
    st_ff.strap_age == 2'h0 |-> st_ff.local_mid[BIT_LONG_REACH])
    else $error("long reach bit not set by reset");
  a_cap_write: assert property (@(posedge I_MCLK) // RULE6
    disable iff (!I_RESETN) s_write_high |=>
    st_ff.local_high[BIT_HS_CAPABLE] == $past(I_WDATA[BIT_HS_CAPABLE]))
    else $error("capable bit write lost");
  a_req_write: assert property (@(posedge I_MCLK) // RULE7
    disable iff (!I_RESETN) s_write_high |=>
    st_ff.local_high[BIT_HS_REQUEST] == $past(I_WDATA[BIT_HS_REQUEST]))
    else $error("request bit write lost");
  a_strap_high: assert property (@(posedge I_MCLK) // RULE18
    disable iff (!I_RESETN) !I_WR && !st_ff.strap_taken &&
    st_ff.strap_age == STRAP_SETTLE |=>
    st_ff.local_high[BIT_HS_CAPABLE] == $past(st_ff.strap_s2[1]) &&
    st_ff.local_high[BIT_HS_REQUEST] == $past(st_ff.strap_s2[0]))
    else $error("high-swing straps not loaded");
  a_strap_kept: assert property (@(posedge I_MCLK) // RULE18
    disable iff (!I_RESETN)
    st_ff.strap_taken && !(I_WR && hit(ADDR_LOCAL_MID))
    |=> $stable(st_ff.local_mid[BIT_ROLE]))
    else $error("role bit changed without a write");
  a_caps_kept: assert property (@(posedge I_MCLK) // RULE18
    disable iff (!I_RESETN)
    st_ff.strap_taken && !(I_WR && hit(ADDR_LOCAL_HIGH))
    |=> $stable(st_ff.local_high))
    else $error("high-swing bits changed without a write");
  // status outputs lag the register, or the forcing input, by one cycle
  a_reach_out: assert property (@(posedge I_MCLK) // RULE2
    disable iff (!I_RESETN) $past(I_RESETN) |->
    O_LONG_REACH == $past(st_ff.local_mid[BIT_LONG_REACH]))
    else $error("long reach output wrong");
  a_cap_out: assert property (@(posedge I_MCLK) // RULE6
    disable iff (!I_RESETN) $past(I_RESETN) |->
    O_HS_CAPABLE == $past(st_ff.local_high[BIT_HS_CAPABLE]))
    else $error("capable output wrong");
  a_req_out: assert property (@(posedge I_MCLK) // RULE7
    disable iff (!I_RESETN) $past(I_RESETN) |->
    O_HS_REQUEST == $past(st_ff.local_high[BIT_HS_REQUEST]))
    else $error("request output wrong");
  a_pref_out: assert property (@(posedge I_MCLK) // RULE4
    disable iff (!I_RESETN)
    $past(I_RESETN) && !$past(I_ROLE_FORCED) |-> !O_ROLE_FORCED)
    else $error("preferred role shown as forced");
  a_level_no_req: assert property (@(posedge I_MCLK) // RULE9
    disable iff (!I_RESETN)
    !st_ff.local_high[BIT_HS_REQUEST] &&
    !st_ff.partner_high[BIT_HS_REQUEST] |=> !O_HIGH_LEVEL)
    else $error("high level without any request");
  // partner page capture
  a_pause_field: assert property (@(posedge I_MCLK) // RULE14
    disable iff (!I_RESETN) I_RX_VALID |=>
    st_ff.partner_low[11:10] == $past(I_RX_LOW[11:10]))
    else $error("partner pause field not captured");
  a_select_field: assert property (@(posedge I_MCLK) // RULE15
    disable iff (!I_RESETN) I_RX_VALID |=>
    st_ff.partner_low[4:0] == $past(I_RX_LOW[4:0]))
    else $error("partner selector not captured");
  a_ack_flag: assert property (@(posedge I_MCLK) // RULE12
    disable iff (!I_RESETN) I_RX_VALID |=>
    st_ff.partner_low[14] == $past(I_RX_LOW[14]))
    else $error("partner acknowledge not captured");
  a_fault_flag: assert property (@(posedge I_MCLK) // RULE13
    disable iff (!I_RESETN) I_RX_VALID |=>
    st_ff.partner_low[13] == $past(I_RX_LOW[13]))
    else $error("partner fault not captured");
  a_partner_ro: assert property (@(posedge I_MCLK) // RULE19
    disable iff (!I_RESETN) I_WR && hit(ADDR_PARTNER_LOW) &&
    !I_RX_VALID |=> $stable(st_ff.partner_low))
    else $error("partner low word took a write");
  a_capture_high: assert property (@(posedge I_MCLK) // RULE10
    disable iff (!I_RESETN)
    s_read_plow |=> sn.held_high == $past(st_ff.partner_high))
    else $error("snapshot missed the partner high word");
  a_snap_read_high: assert property (@(posedge I_MCLK) // RULE17
    disable iff (!I_RESETN) I_RD && hit(ADDR_PARTNER_HIGH)
    |=> O_RDATA == $past(sn.held_high))
    else $error("partner high read not from snapshot");
  a_live_hidden: assert property (@(posedge I_MCLK) // RULE17
    disable iff (!I_RESETN) !(I_RD && hit(ADDR_PARTNER_LOW))
    |=> $stable(sn.held_mid) && $stable(sn.held_high))
    else $error("snapshot followed the live page");
endmodule
`default_nettype wire

// ==== logic/an_regs_pkg.sv ====
// constants for the autonegotiation ability register bank
package an_regs_pkg;
  localparam logic [15:0] ADDR_LOCAL_MID = 16'h0203;
  localparam logic [15:0] ADDR_LOCAL_HIGH = 16'h0204;
  localparam logic [15:0] ADDR_PARTNER_LOW = 16'h0205;
  localparam logic [15:0] ADDR_PARTNER_MID = 16'h0206;
  localparam logic [15:0] ADDR_PARTNER_HIGH = 16'h0207;
  localparam logic [4:0] MMD_AUTONEG = 5'h07;
  localparam logic [15:0] RST_LOCAL_MID = 16'h4000;
  localparam logic [15:0] RST_LOCAL_HIGH = 16'h0000;
  localparam logic [15:0] RST_PARTNER_LOW = 16'h0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int BIT_LONG_REACH = 14;
  localparam int BIT_ROLE = 4;
  localparam int BIT_HS_CAPABLE = 13;
  localparam int BIT_HS_REQUEST = 12;
  localparam int BIT_ROLE_FORCED = 12;
  localparam int NONCE_ROLE_BIT = 4;
  localparam logic [15:0] MASK_LOCAL_MID = 16'h4010;
  localparam logic [15:0] MASK_LOCAL_HIGH = 16'h3000;
  localparam logic [15:0] MASK_PARTNER_LOW = 16'hEC1F;
  localparam logic [4:0] SELECTOR_STD = 5'h01;
endpackage

// ==== logic/partner_snapshot.sv ====
// snapshot store for partner middle and high ability words
`timescale 1ns/1ps
`default_nettype none
module partner_snapshot
  import an_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  snap_if.store sn
);
  typedef struct packed {
    logic [15:0] mid;
    logic [15:0] high;
  } snap_state_t;
  snap_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // RULE10 capture on low read
    if (sn.capture) begin
      nxt_st.mid = sn.live_mid;
      nxt_st.high = sn.live_high;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sn.held_mid = st_ff.mid;
  assign sn.held_high = st_ff.high;

  a_snap_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sn.capture |=> $stable(st_ff)) // RULE17
    else $error("snapshot changed without a low-word read");
  a_snap_takes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sn.capture |=> st_ff.mid == $past(sn.live_mid)) // RULE10
    else $error("snapshot missed the live middle word");
endmodule
`default_nettype wire

// ==== logic/snap_if.sv ====
// carrier for the partner word snapshot between bank and snapshot store
`timescale 1ns/1ps
`default_nettype none
interface snap_if;
  logic capture;
  logic [15:0] live_mid;
  logic [15:0] live_high;
  logic [15:0] held_mid;
  logic [15:0] held_high;
  modport bank(output capture, live_mid, live_high,
               input held_mid, held_high);
  modport store(input capture, live_mid, live_high,
                output held_mid, held_high);
endinterface
`default_nettype wire

// ==== sim/an_link_partner.sv ====
// behavioural remote link partner that delivers received base pages
`timescale 1ns/1ps
`default_nettype none
module an_link_partner (
  input wire logic i_clk,
  output logic o_valid,
  output logic [15:0] o_low,
  output logic [15:0] o_mid,
  output logic [15:0] o_high
);
  initial begin
    o_valid = 1'b0;
    o_low = 16'h0000;
    o_mid = 16'h0000;
    o_high = 16'h0000;
  end
  task automatic send(input logic [15:0] l, m, h);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_low <= l;
    o_mid <= m;
    o_high <= h;
    @(posedge i_clk);
    // words are stale after the pulse; flipping them exposes late sampling
    o_valid <= 1'b0;
    o_low <= ~l;
    o_mid <= ~m;
    o_high <= ~h;
  endtask
endmodule
`default_nettype wire

// ==== sim/t1_autoneg_ability_regs_tb.sv ====
// register level testbench for the autonegotiation ability bank
`timescale 1ns/1ps
`default_nettype none
module t1_autoneg_ability_regs_tb;
  import an_regs_pkg::*;
  logic clk, rst_n, wr, rd, s_role, s_cap, s_req, forced_in;
  logic [4:0] mmd;
  logic [15:0] addr, wdata, rdata;
  logic tx_role, forced_out, long_reach, hs_cap, hs_req, high_lvl;
  logic rx_valid;
  logic [15:0] rx_low, rx_mid, rx_high;
  int err_count = 0;
  int n_compared = 0;
  an_ability_regs u_dut (.I_MCLK(clk), .I_RESETN(rst_n), .I_MMD(mmd),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_STRAP_ROLE(s_role), .I_STRAP_HS_CAPABLE(s_cap),
    .I_STRAP_HS_REQUEST(s_req), .I_ROLE_FORCED(forced_in),
    .I_RX_VALID(rx_valid), .I_RX_LOW(rx_low), .I_RX_MID(rx_mid),
    .I_RX_HIGH(rx_high), .O_TX_NONCE_ROLE(tx_role),
    .O_ROLE_FORCED(forced_out), .O_LONG_REACH(long_reach),
    .O_HS_CAPABLE(hs_cap), .O_HS_REQUEST(hs_req), .O_HIGH_LEVEL(high_lvl));
  an_link_partner u_lp (.i_clk(clk), .o_valid(rx_valid), .o_low(rx_low),
    .o_mid(rx_mid), .o_high(rx_high));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [15:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    s_role <= s;
    s_cap <= s;
    s_req <= s;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic lc, lr, pc, pr;
    {wr, rd, forced_in} = 3'b000;
    mmd = MMD_AUTONEG;
    addr = 16'h0000;
    wdata = 16'h0000;
    rst_n = 1'b0;
    {s_role, s_cap, s_req} = 3'b111;
    do_reset(1'b1);
    reg_rd(ADDR_LOCAL_MID, 16'h4010);
    reg_rd(ADDR_LOCAL_HIGH, 16'h3000);
    chk({15'h0000, tx_role}, 16'h0001);
    $display("strap reset test done");
    reg_wr(ADDR_LOCAL_MID, 16'hFFFF);
    reg_rd(ADDR_LOCAL_MID, 16'h4010);
    reg_wr(ADDR_LOCAL_MID, 16'h0000);
    reg_rd(ADDR_LOCAL_MID, 16'h0000);
    chk({14'h0000, long_reach, tx_role}, 16'h0000);
    reg_wr(ADDR_LOCAL_HIGH, 16'hFFFF);
    reg_rd(ADDR_LOCAL_HIGH, 16'h3000);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      forced_in <= f[0];
      repeat (3) @(posedge clk);
      chk({15'h0000, forced_out}, {15'h0000, f[0]});
    end
    $display("local word test done");
    // each pass snapshots the partner page before judging the level
    for (int i = 0; i < 16; i++) begin
      {lc, lr, pc, pr} = i[3:0];
      reg_wr(ADDR_LOCAL_HIGH, {2'b00, lc, lr, 12'h000});
      u_lp.send(16'h0001, 16'h4000, {2'b00, pc, pr, 12'h000});
      reg_rd(ADDR_PARTNER_LOW, 16'h0001);
      repeat (3) @(posedge clk);
      chk({14'h0000, hs_cap, hs_req}, {14'h0000, lc, lr});
      chk({15'h0000, high_lvl}, {15'h0000, lc & pc & (lr | pr)});
    end
    $display("level resolution test done");
    u_lp.send(16'hFFFF, 16'h4010, 16'h3000);
    reg_rd(ADDR_PARTNER_LOW, 16'hEC1F);
    u_lp.send(16'h0001, 16'h00E0, 16'h2000);
    reg_rd(ADDR_PARTNER_MID, 16'h4010);
    reg_rd(ADDR_PARTNER_HIGH, 16'h3000);
    reg_rd(ADDR_PARTNER_LOW, 16'h0001);
    reg_rd(ADDR_PARTNER_MID, 16'h00E0);
    reg_rd(ADDR_PARTNER_HIGH, 16'h2000);
    reg_wr(ADDR_PARTNER_LOW, 16'hFFFF);
    reg_rd(ADDR_PARTNER_LOW, 16'h0001);
    reg_rd(16'h0208, 16'h0000);
    mmd <= 5'h01;
    reg_wr(ADDR_LOCAL_MID, 16'h4010);
    reg_rd(ADDR_LOCAL_MID, 16'h0000);
    mmd <= MMD_AUTONEG;
    reg_rd(ADDR_LOCAL_MID, 16'h0000);
    $display("partner and decode test done");
    do_reset(1'b0);
    reg_rd(ADDR_LOCAL_MID, 16'h4000);
    reg_rd(ADDR_LOCAL_HIGH, 16'h0000);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
